// file: lscc_pkg.sv
// Overview of operation
// - A configuration write abandons any running conversion at once, with no result and no ready flag.
// - After a configuration write whose mode asks for conversions, a fresh conversion starts with the new settings.
// - The range selector in bits 15 to 12 picks the full-scale range with the same coding as the result exponent.
// - Range selector 1100b selects automatic ranging, and the chosen range is reported as the result exponent.
// - The configuration register resets to C810h, so automatic ranging is active from reset.
// - Bit 11 sets the integration length, 0 for 100 ms and 1 for 800 ms, and resets to 1.
// - With 100 ms, resolution drops one bit at range 0101b, two at 0100b to 0001b, three at 0000b.
// - The result layout and its LSB weight do not depend on the integration time.
// - Mode bits 10 to 9 decode 00 as shutdown, 01 as one conversion, 10 or 11 as continuous conversions.
// - A single conversion keeps the mode at 01b while converting and clears it to 00b when done.
// - Entering shutdown leaves the ready, high and low flags unchanged.
// - Bits 15 to 9 and 4 to 0 are read/write; bits 8 to 5 are read-only status.
// - The ready flag sets at the end of a conversion and clears on a later read or non-shutdown write.
// - In automatic ranging an overflow below the top range aborts, steps the range up and restarts.
// - The high and low flags set after the fault-count number of consecutive results beyond the limits.
package lscc_pkg;
    // Timing of the integration window
    localparam int CLK_HZ = 50_000_000;
    localparam int HZ_PER_KHZ = 1000;
    localparam int SHORT_INT_MS = 100;
    localparam int LONG_INT_MS = 800;
    localparam int SHORT_INT_CYCLES = SHORT_INT_MS * (CLK_HZ / HZ_PER_KHZ);
    localparam int LONG_INT_CYCLES = LONG_INT_MS * (CLK_HZ / HZ_PER_KHZ);
    localparam int TIMER_W = 26;

    // Register map and field constants
    localparam logic [7:0] CFG_OFFSET = 8'h01;
    localparam logic [15:0] CFG_RESET = 16'hC810;
    localparam logic [15:0] CFG_WR_MASK = 16'hFE1F;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam logic [3:0] RANGE_MIN = 4'h0;
    localparam logic [3:0] RANGE_LOSS_ONE = 4'h5;
    localparam logic [3:0] RANGE_MAX = 4'hB;
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    localparam logic [3:0] RANGE_STEP = 4'h1;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] LOSS_NONE = 2'h0;
    localparam logic [1:0] LOSS_ONE = 2'h1;
    localparam logic [1:0] LOSS_TWO = 2'h2;
    localparam logic [1:0] LOSS_THREE = 2'h3;
    localparam logic [3:0] FAULT_CNT_ONE = 4'h1;
    localparam int LUX_W = 27;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } lscc_state_e;

    typedef struct packed {
        logic [3:0] rangeSelect;
        logic integrationTimeSel;
        logic [1:0] opMode;
        logic overrangeFlag;
        logic conversionDoneFlag;
        logic aboveLimitFlag;
        logic belowLimitFlag;
        logic latchModeSel;
        logic irqPolaritySel;
        logic exponentMaskEn;
        logic [1:0] consecutiveFaultCount;
    } lscc_cfg_s;

    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } lscc_result_s;

    // Consecutive results needed: 1, 2, 4 or 8
    function automatic logic [3:0] faultLimit(input logic [1:0] fc);
        faultLimit = FAULT_CNT_ONE << fc;
    endfunction

    // Lux in units of the smallest LSB
    function automatic logic [LUX_W-1:0] luxOf(input lscc_result_s r);
        luxOf = LUX_W'(r.mantissa) << r.exponent;
    endfunction
endpackage

// file: lscc_config_control.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the level moves once stages two and three agree
module lscc_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic s1;
    logic s2;
    logic s3;
    logic next_q;

    // Stage one feeds stage two only
    always_comb begin
        next_q = (s2 == s3) ? s3 : q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule

module lscc_config_control #(
    parameter int SHORT_CYCLES = lscc_pkg::SHORT_INT_CYCLES,
    parameter int LONG_CYCLES = lscc_pkg::LONG_INT_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic linkClk,
    input wire logic linkWrStb,
    input wire logic linkRdStb,
    input wire logic [7:0] linkAddr,
    input wire logic [15:0] linkWrData,
    output logic linkReady,
    output logic [15:0] linkRdData,
    output logic linkRdValid,
    input wire logic [11:0] afeMantissa,
    input wire logic afeOverflow,
    output logic afeIntegrate,
    output logic [3:0] afeRange,
    output logic afeLongInt,
    input wire lscc_pkg::lscc_result_s highLimit,
    input wire lscc_pkg::lscc_result_s lowLimit,
    output lscc_pkg::lscc_result_s resultWord,
    output logic resultValid,
    output lscc_pkg::lscc_cfg_s cfgWord,
    output logic [1:0] resolutionLoss
);
    // Link domain state
    logic linkRst;
    logic wrTog;
    logic rdTog;
    logic [23:0] wrHold;
    logic [7:0] rdAddrHold;
    logic rdAckPrev;
    logic wrAckL;
    logic rdAckL;
    logic next_wrTog;
    logic next_rdTog;
    logic [23:0] next_wrHold;
    logic [7:0] next_rdAddrHold;
    logic next_rdAckPrev;
    logic [15:0] next_linkRdData;
    logic next_linkRdValid;
    logic linkPending;

    // Core domain state
    lscc_pkg::lscc_state_e state;
    lscc_pkg::lscc_state_e next_state;
    lscc_pkg::lscc_cfg_s cfg;
    lscc_pkg::lscc_cfg_s next_cfg;
    lscc_pkg::lscc_cfg_s wrCfg;
    lscc_pkg::lscc_result_s next_resultWord;
    logic [lscc_pkg::TIMER_W-1:0] timer;
    logic [lscc_pkg::TIMER_W-1:0] next_timer;
    logic [lscc_pkg::TIMER_W-1:0] intLimit;
    logic [3:0] curRange;
    logic [3:0] next_curRange;
    logic [3:0] aboveCnt;
    logic [3:0] next_aboveCnt;
    logic [3:0] belowCnt;
    logic [3:0] next_belowCnt;
    logic [15:0] rdHold;
    logic [15:0] next_rdHold;
    logic next_resultValid;
    logic wrSeen;
    logic rdSeen;
    logic wrSeenPrev;
    logic rdSeenPrev;
    logic wrEvt;
    logic rdEvt;
    logic cfgWrEvt;
    logic cfgRdEvt;
    logic autoMode;
    logic doneNow;
    logic stepUp;
    logic isAbove;
    logic isBelow;
    logic [11:0] keepMask;
    lscc_pkg::lscc_result_s sample;

    // Link reset follows the core reset; valid only while the link clock runs
    lscc_sync3 uRstSync (.clk(linkClk), .rst(1'b0), .d(srst), .q(linkRst));
    lscc_sync3 uWrSync (.clk(mclk), .rst(srst), .d(wrTog), .q(wrSeen));
    lscc_sync3 uRdSync (.clk(mclk), .rst(srst), .d(rdTog), .q(rdSeen));
    lscc_sync3 uWrAck (.clk(linkClk), .rst(linkRst), .d(wrSeenPrev), .q(wrAckL));
    lscc_sync3 uRdAck (.clk(linkClk), .rst(linkRst), .d(rdSeenPrev), .q(rdAckL));

    // One request in flight; held words stay stable until the core acknowledges
    assign linkPending = (wrTog != wrAckL) | (rdTog != rdAckL);
    assign linkReady = ~linkPending & ~linkRst;

    // Link side: capture a request, toggle it across, return read data
    always_comb begin
        next_wrTog = wrTog;
        next_rdTog = rdTog;
        next_wrHold = wrHold;
        next_rdAddrHold = rdAddrHold;
        next_rdAckPrev = rdAckL;
        next_linkRdData = linkRdData;
        next_linkRdValid = 1'b0;
        if (linkReady && linkWrStb) begin
            next_wrHold = {linkAddr, linkWrData};
            next_wrTog = ~wrTog;
        end else if (linkReady && linkRdStb) begin
            next_rdAddrHold = linkAddr;
            next_rdTog = ~rdTog;
        end
        if (rdAckL != rdAckPrev) begin
            next_linkRdData = rdHold;
            next_linkRdValid = 1'b1;
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            wrTog <= 1'b0;
            rdTog <= 1'b0;
            wrHold <= '0;
            rdAddrHold <= '0;
            rdAckPrev <= 1'b0;
            linkRdData <= lscc_pkg::READ_ZERO;
            linkRdValid <= 1'b0;
        end else begin
            wrTog <= next_wrTog;
            rdTog <= next_rdTog;
            wrHold <= next_wrHold;
            rdAddrHold <= next_rdAddrHold;
            rdAckPrev <= next_rdAckPrev;
            linkRdData <= next_linkRdData;
            linkRdValid <= next_linkRdValid;
        end
    end

    // Core-side decode of crossed requests
    assign wrEvt = wrSeen != wrSeenPrev;
    assign rdEvt = rdSeen != rdSeenPrev;
    assign cfgWrEvt = wrEvt && (wrHold[23:16] == lscc_pkg::CFG_OFFSET);
    assign cfgRdEvt = rdEvt && (rdAddrHold == lscc_pkg::CFG_OFFSET);
    assign wrCfg = (cfg & ~lscc_pkg::CFG_WR_MASK) | (wrHold[15:0] & lscc_pkg::CFG_WR_MASK);
    assign autoMode = cfg.rangeSelect == lscc_pkg::RANGE_AUTO;
    assign intLimit = cfg.integrationTimeSel ? lscc_pkg::TIMER_W'(LONG_CYCLES)
                                             : lscc_pkg::TIMER_W'(SHORT_CYCLES);
    assign doneNow = (state == lscc_pkg::ST_CONV) && (timer == intLimit - lscc_pkg::TIMER_W'(1));
    assign stepUp = (state == lscc_pkg::ST_CONV) && autoMode && afeOverflow
                    && (curRange != lscc_pkg::RANGE_MAX);

    // Short integration costs low bits at the small ranges; format is unchanged
    always_comb begin
        if (cfg.integrationTimeSel || curRange > lscc_pkg::RANGE_LOSS_ONE) begin
            resolutionLoss = lscc_pkg::LOSS_NONE;
        end else if (curRange == lscc_pkg::RANGE_LOSS_ONE) begin
            resolutionLoss = lscc_pkg::LOSS_ONE;
        end else if (curRange == lscc_pkg::RANGE_MIN) begin
            resolutionLoss = lscc_pkg::LOSS_THREE;
        end else begin
            resolutionLoss = lscc_pkg::LOSS_TWO;
        end
    end

    // Sample as it will be stored: same layout and LSB for both times
    assign keepMask = 12'hFFF << resolutionLoss;
    assign sample.exponent = (cfg.exponentMaskEn && !autoMode) ? lscc_pkg::RANGE_MIN : curRange;
    assign sample.mantissa = afeMantissa & keepMask;
    assign isAbove = lscc_pkg::luxOf(sample) > lscc_pkg::luxOf(highLimit);
    assign isBelow = lscc_pkg::luxOf(sample) < lscc_pkg::luxOf(lowLimit);

    // Conversion control: a write outranks range stepping, which outranks completion
    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_timer = timer;
        next_curRange = curRange;
        next_aboveCnt = aboveCnt;
        next_belowCnt = belowCnt;
        next_rdHold = rdHold;
        next_resultWord = resultWord;
        next_resultValid = 1'b0;
        if (rdEvt) begin
            next_rdHold = cfgRdEvt ? cfg : lscc_pkg::READ_ZERO;
        end
        if (cfgRdEvt) begin
            next_cfg.conversionDoneFlag = 1'b0;
            if (cfg.latchModeSel) begin
                next_cfg.aboveLimitFlag = 1'b0;
                next_cfg.belowLimitFlag = 1'b0;
            end
        end
        if (cfgWrEvt) begin
            next_cfg = wrCfg;
            next_state = lscc_pkg::ST_IDLE;
            next_timer = '0;
            if (wrCfg.opMode != lscc_pkg::MODE_SHUTDOWN) begin
                next_cfg.conversionDoneFlag = 1'b0;
                next_state = lscc_pkg::ST_CONV;
                // Auto ranging climbs from the most sensitive range
                next_curRange = (wrCfg.rangeSelect == lscc_pkg::RANGE_AUTO) ? lscc_pkg::RANGE_MIN
                                                                            : wrCfg.rangeSelect;
            end
        end else if (stepUp) begin
            next_curRange = curRange + lscc_pkg::RANGE_STEP;
            next_timer = '0;
        end else if (doneNow) begin
            next_resultWord = sample;
            next_resultValid = 1'b1;
            next_cfg.conversionDoneFlag = 1'b1;
            next_cfg.overrangeFlag = afeOverflow;
            next_timer = '0;
            if (isAbove) begin
                next_aboveCnt = (aboveCnt < lscc_pkg::faultLimit(cfg.consecutiveFaultCount))
                                ? aboveCnt + lscc_pkg::FAULT_CNT_ONE : aboveCnt;
                if (next_aboveCnt >= lscc_pkg::faultLimit(cfg.consecutiveFaultCount)) begin
                    next_cfg.aboveLimitFlag = 1'b1;
                end
            end else begin
                next_aboveCnt = '0;
                if (!cfg.latchModeSel) begin
                    next_cfg.aboveLimitFlag = 1'b0;
                end
            end
            if (isBelow) begin
                next_belowCnt = (belowCnt < lscc_pkg::faultLimit(cfg.consecutiveFaultCount))
                                ? belowCnt + lscc_pkg::FAULT_CNT_ONE : belowCnt;
                if (next_belowCnt >= lscc_pkg::faultLimit(cfg.consecutiveFaultCount)) begin
                    next_cfg.belowLimitFlag = 1'b1;
                end
            end else begin
                next_belowCnt = '0;
                if (!cfg.latchModeSel) begin
                    next_cfg.belowLimitFlag = 1'b0;
                end
            end
            // Flags are left alone on the way into shutdown
            if (cfg.opMode == lscc_pkg::MODE_SINGLE) begin
                next_cfg.opMode = lscc_pkg::MODE_SHUTDOWN;
                next_state = lscc_pkg::ST_IDLE;
            end
        end else if (state == lscc_pkg::ST_CONV) begin
            next_timer = timer + lscc_pkg::TIMER_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= lscc_pkg::ST_IDLE;
            cfg <= lscc_pkg::CFG_RESET;
            timer <= '0;
            curRange <= lscc_pkg::RANGE_MIN;
            aboveCnt <= '0;
            belowCnt <= '0;
            rdHold <= lscc_pkg::READ_ZERO;
            resultWord <= '0;
            resultValid <= 1'b0;
            wrSeenPrev <= 1'b0;
            rdSeenPrev <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            timer <= next_timer;
            curRange <= next_curRange;
            aboveCnt <= next_aboveCnt;
            belowCnt <= next_belowCnt;
            rdHold <= next_rdHold;
            resultWord <= next_resultWord;
            resultValid <= next_resultValid;
            wrSeenPrev <= wrSeen;
            rdSeenPrev <= rdSeen;
        end
    end

    // Front-end steering
    assign afeIntegrate = state == lscc_pkg::ST_CONV;
    assign afeRange = curRange;
    assign afeLongInt = cfg.integrationTimeSel;
    assign cfgWord = cfg;

    a_write_abort: assert property (@(posedge mclk) disable iff (srst)
        cfgWrEvt && wrCfg.opMode == lscc_pkg::MODE_SHUTDOWN |=> state == lscc_pkg::ST_IDLE && !resultValid)
        else $error("write did not abort conversion");
    a_write_start: assert property (@(posedge mclk) disable iff (srst)
        cfgWrEvt && wrCfg.opMode != lscc_pkg::MODE_SHUTDOWN |=> state == lscc_pkg::ST_CONV && timer == '0)
        else $error("write did not start conversion");
    a_manual_range: assert property (@(posedge mclk) disable iff (srst)
        state == lscc_pkg::ST_CONV && !autoMode |-> afeRange == cfg.rangeSelect)
        else $error("manual range not applied");
    a_auto_exponent: assert property (@(posedge mclk) disable iff (srst)
        doneNow && autoMode && !cfgWrEvt && !stepUp |=> resultValid && resultWord.exponent == $past(curRange))
        else $error("auto range not reported");
    a_reset_value: assert property (@(posedge mclk)
        $past(srst) |-> cfg == lscc_pkg::CFG_RESET)
        else $error("config reset value wrong");
    a_int_length: assert property (@(posedge mclk) disable iff (srst)
        state == lscc_pkg::ST_CONV |-> timer < intLimit)
        else $error("integration overran");
    a_loss_long: assert property (@(posedge mclk) disable iff (srst)
        cfg.integrationTimeSel |-> resolutionLoss == lscc_pkg::LOSS_NONE)
        else $error("resolution lost at long time");
    a_cont_restart: assert property (@(posedge mclk) disable iff (srst)
        doneNow && cfg.opMode[1] && !cfgWrEvt |=> state == lscc_pkg::ST_CONV && timer == '0)
        else $error("continuous mode stopped");
    a_single_clear: assert property (@(posedge mclk) disable iff (srst)
        doneNow && cfg.opMode == lscc_pkg::MODE_SINGLE && !cfgWrEvt && !stepUp
        |=> cfg.opMode == lscc_pkg::MODE_SHUTDOWN && state == lscc_pkg::ST_IDLE)
        else $error("single shot did not clear mode");
    a_shutdown_keep: assert property (@(posedge mclk) disable iff (srst)
        cfgWrEvt && wrCfg.opMode == lscc_pkg::MODE_SHUTDOWN
        |=> cfg.conversionDoneFlag == $past(cfg.conversionDoneFlag)
            && cfg.aboveLimitFlag == $past(cfg.aboveLimitFlag))
        else $error("shutdown changed flags");
    a_done_flag: assert property (@(posedge mclk) disable iff (srst)
        doneNow && !cfgWrEvt && !stepUp |=> cfg.conversionDoneFlag)
        else $error("ready flag not set");
    a_ready_clear: assert property (@(posedge mclk) disable iff (srst)
        cfgRdEvt && !doneNow |=> !cfg.conversionDoneFlag)
        else $error("ready flag not cleared by read");
    a_status_ro: assert property (@(posedge mclk) disable iff (srst)
        cfgWrEvt |=> cfg.overrangeFlag == $past(cfg.overrangeFlag))
        else $error("write touched status bit");
    a_range_step: assert property (@(posedge mclk) disable iff (srst)
        stepUp && !cfgWrEvt |=> curRange == $past(curRange) + lscc_pkg::RANGE_STEP && timer == '0)
        else $error("auto range did not step");
endmodule

// file: lscc_afe_model.sv
`timescale 1ns/1ps
module lscc_afe_model (
    input wire logic mclk,
    input wire logic afeIntegrate,
    input wire logic [3:0] afeRange,
    input wire logic [26:0] lightLevel,
    output logic [11:0] afeMantissa,
    output logic afeOverflow
);
    logic [26:0] scaled;
    logic [11:0] idleBits = 12'ha5a;

    // Light above the selected full scale saturates the integrator
    always_comb begin
        scaled = lightLevel >> afeRange;
        afeOverflow = afeIntegrate && (scaled > 27'h000_0fff);
        afeMantissa = afeOverflow ? 12'hfff : scaled[11:0];
        if (!afeIntegrate) begin
            afeMantissa = idleBits;
        end
    end

    // Idle output toggles every cycle so a stale sample never looks valid
    always_ff @(posedge mclk) begin
        idleBits <= ~idleBits;
    end
endmodule

// file: lscc_config_control_tb_top.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin failCount++; $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); end end
module lscc_config_control_tb_top;
    localparam int SHORT = 60;
    localparam int LONG = 200;
    logic mclk = 1'b0;
    logic linkClk = 1'b0;
    logic srst = 1'b1;
    logic linkWrStb = 1'b0;
    logic linkRdStb = 1'b0;
    logic [7:0] linkAddr = 8'h00;
    logic [15:0] linkWrData = 16'h0000;
    logic linkReady;
    logic [15:0] linkRdData;
    logic linkRdValid;
    logic [11:0] afeMantissa;
    logic afeOverflow;
    logic afeIntegrate;
    logic [3:0] afeRange;
    logic afeLongInt;
    lscc_pkg::lscc_result_s highLimit = 16'hbfff;
    lscc_pkg::lscc_result_s lowLimit = 16'h0000;
    lscc_pkg::lscc_result_s resultWord;
    lscc_pkg::lscc_result_s lastResult;
    logic resultValid;
    lscc_pkg::lscc_cfg_s cfgWord;
    logic [1:0] resolutionLoss;
    logic [26:0] lightLevel = 27'h000_0abc;
    logic [15:0] rd;
    logic [11:0] expMant;
    logic [1:0] expLoss;
    int failCount = 0;
    int compares = 0;
    int resultCount = 0;
    int base;

    // Core and link clocks, unrelated rates
    always #10 mclk = ~mclk;
    always #15 linkClk = ~linkClk;

    lscc_config_control #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) i_dut (
        .mclk(mclk), .srst(srst), .linkClk(linkClk), .linkWrStb(linkWrStb), .linkRdStb(linkRdStb),
        .linkAddr(linkAddr), .linkWrData(linkWrData), .linkReady(linkReady), .linkRdData(linkRdData),
        .linkRdValid(linkRdValid), .afeMantissa(afeMantissa), .afeOverflow(afeOverflow),
        .afeIntegrate(afeIntegrate), .afeRange(afeRange), .afeLongInt(afeLongInt), .highLimit(highLimit),
        .lowLimit(lowLimit), .resultWord(resultWord), .resultValid(resultValid), .cfgWord(cfgWord),
        .resolutionLoss(resolutionLoss)
    );

    lscc_afe_model i_afe (
        .mclk(mclk), .afeIntegrate(afeIntegrate), .afeRange(afeRange), .lightLevel(lightLevel),
        .afeMantissa(afeMantissa), .afeOverflow(afeOverflow)
    );

    // Result pulses are counted away from the edge that launches them
    always @(negedge mclk) begin
        if (resultValid === 1'b1) begin
            resultCount++;
            lastResult = resultWord;
        end
    end

    task automatic stopTest();
        $display("counts: %0d compares, %0d mismatches", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Ready is sampled on the falling link edge, clear of its own updates
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(negedge linkClk);
            n++;
            if (n > 80) begin
                failCount++;
                stopTest();
            end
        end while (linkReady !== 1'b1);
    endtask

    // Released qualifiers show inverted values so stale data cannot pass
    task automatic linkWrite(input logic [7:0] addr, input logic [15:0] data);
        waitReady();
        @(posedge linkClk);
        linkWrStb <= 1'b1;
        linkAddr <= addr;
        linkWrData <= data;
        @(posedge linkClk);
        linkWrStb <= 1'b0;
        linkAddr <= ~addr;
        linkWrData <= ~data;
        waitReady();
    endtask

    task automatic linkRead(input logic [7:0] addr, output logic [15:0] data);
        int n;
        waitReady();
        @(posedge linkClk);
        linkRdStb <= 1'b1;
        linkAddr <= addr;
        @(posedge linkClk);
        linkRdStb <= 1'b0;
        linkAddr <= ~addr;
        n = 0;
        do begin
            @(negedge linkClk);
            n++;
            if (n > 80) begin
                failCount++;
                stopTest();
            end
        end while (linkRdValid !== 1'b1);
        data = linkRdData;
    endtask

    task automatic waitCount(input int target, input int bound);
        int n;
        n = 0;
        while (resultCount < target) begin
            @(negedge mclk);
            n++;
            if (n > bound) begin
                failCount++;
                stopTest();
            end
        end
    endtask

    // Hang guard for the whole run
    initial begin
        repeat (100000) @(posedge mclk);
        failCount++;
        stopTest();
    end

    // Main sequence; reserved range codes are never written
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        `CHECK(cfgWord, 16'hc810)
        linkRead(8'h01, rd);
        `CHECK(rd, 16'hc810)
        `CHECK(afeIntegrate, 1'b0)
        linkRead(8'h02, rd);
        `CHECK(rd, 16'h0000)
        $display("test reset done");
        linkWrite(8'h01, 16'hb9ff);
        `CHECK(cfgWord, 16'hb81f)
        linkWrite(8'h02, 16'h3200);
        linkRead(8'h01, rd);
        `CHECK(rd, 16'hb81f)
        `CHECK(afeIntegrate, 1'b0)
        $display("test access done");
        for (int ct = 0; ct < 2; ct++) begin
            for (int r = 0; r < 12; r++) begin
                expLoss = (ct == 1 || r > 5) ? 2'h0 : (r == 0) ? 2'h3 : (r == 5) ? 2'h1 : 2'h2;
                expMant = 12'(27'h000_0abc >> r) & ~((12'h001 << expLoss) - 12'h001);
                base = resultCount;
                linkWrite(8'h01, {4'(r), 1'(ct), 2'b01, 9'h000});
                `CHECK(afeIntegrate, 1'b1)
                `CHECK(afeRange, 4'(r))
                `CHECK(afeLongInt, 1'(ct))
                `CHECK(resolutionLoss, expLoss)
                `CHECK(cfgWord.opMode, 2'b01)
                waitCount(base + 1, LONG + 40);
                `CHECK(lastResult, {4'(r), expMant})
                @(negedge mclk);
                `CHECK(cfgWord, {4'(r), 1'(ct), 2'b00, 2'b01, 7'h00})
                `CHECK(afeIntegrate, 1'b0)
            end
        end
        $display("test ranges done");
        linkWrite(8'h01, 16'hb800);
        linkRead(8'h01, rd);
        `CHECK(rd, 16'hb880)
        linkRead(8'h01, rd);
        `CHECK(rd, 16'hb800)
        $display("test ready flag done");
        base = resultCount;
        linkWrite(8'h01, 16'h3200);
        repeat (8) @(negedge mclk);
        linkWrite(8'h01, 16'h5200);
        waitCount(base + 1, SHORT + 40);
        repeat (SHORT + 20) @(negedge mclk);
        `CHECK(resultCount, base + 1)
        `CHECK(lastResult.exponent, 4'h5)
        $display("test abort done");
        @(posedge mclk);
        lightLevel <= 27'h000_5000;
        highLimit <= 16'h0100;
        base = resultCount;
        linkWrite(8'h01, 16'hc200);
        waitCount(base + 1, 13 * SHORT + 100);
        `CHECK(lastResult, 16'h3a00)
        `CHECK(cfgWord.rangeSelect, 4'hc)
        linkRead(8'h01, rd);
        `CHECK(rd, 16'hc0c0)
        @(posedge mclk);
        lightLevel <= 27'h7ff_ffff;
        base = resultCount;
        linkWrite(8'h01, 16'hca00);
        waitCount(base + 1, 13 * LONG + 100);
        `CHECK(lastResult.exponent, 4'hb)
        `CHECK(cfgWord.overrangeFlag, 1'b1)
        $display("test auto range done");
        @(posedge mclk);
        lightLevel <= 27'h000_0abc;
        highLimit <= 16'hbfff;
        lowLimit <= 16'hbfff;
        // Two results in a row are needed below the limit; the second pass also masks the exponent
        for (int m = 2; m < 4; m++) begin
            base = resultCount;
            linkWrite(8'h01, {4'h3, 1'b0, 2'(m), 6'h00, 1'(m == 3), 2'b01});
            waitCount(base + 1, 2 * SHORT + 40);
            if (m == 2) begin
                `CHECK(cfgWord.belowLimitFlag, 1'b0)
            end
            waitCount(base + 2, 2 * SHORT + 40);
            `CHECK(cfgWord.opMode, 2'(m))
            `CHECK(afeIntegrate, 1'b1)
            `CHECK(cfgWord.belowLimitFlag, 1'b1)
            `CHECK(lastResult.exponent, (m == 3) ? 4'h0 : 4'h3)
        end
        linkWrite(8'h01, 16'h3000);
        `CHECK(afeIntegrate, 1'b0)
        linkRead(8'h01, rd);
        `CHECK(rd[7], 1'b1)
        `CHECK(rd[5], 1'b1)
        $display("test continuous done");
        stopTest();
    end
endmodule
